// File: core/atr_pkg.sv
package atr_pkg;
    // Fixed ATR frame layout sent by the card end
    localparam logic [7:0] TS_DIRECT    = 8'h3b;
    localparam logic [7:0] T0_FORMAT    = 8'h97;  // TA1 and TD1 follow, seven historical bytes
    localparam logic [7:0] TD1_BYTE     = 8'h80;  // TD2 follows, T=0 offered
    localparam logic [7:0] TD2_BYTE     = 8'h3f;  // TA3 and TB3 follow, T=15
    localparam logic [7:0] CAT_COMPACT  = 8'h80;
    localparam logic [7:0] TAG_SERVICE  = 8'h31;
    localparam logic [7:0] TAG_CAPS     = 8'h73;
    localparam logic [3:0] ATR_LAST     = 4'he;   // Index of the check byte
    localparam logic [3:0] HIST_LEN     = 4'h7;
    // Presence nibble bits of T0 and TDi
    localparam int         PRES_TA      = 0;
    localparam int         PRES_TB      = 1;
    localparam int         PRES_TD      = 3;
    localparam logic [3:0] PROTO_GLOBAL = 4'hf;
    // First TB after T=15
    localparam logic [7:0] TB15_NONE    = 8'h00;
    localparam logic [7:0] TB15_LOWIMP  = 8'hb4;
    // Transmission factor codes, FI in the high nibble and DI in the low one
    localparam logic [7:0] FIDI_DEFAULT = 8'h11;
    localparam logic [7:0] FIDI_512_8   = 8'h94;
    localparam logic [7:0] FIDI_512_16  = 8'h95;
    localparam logic [3:0] FI_FOR_D64   = 4'h9;
    localparam logic [3:0] DI_D64       = 4'h7;
    // Parameter selection frame
    localparam logic [7:0] PPSS_BYTE    = 8'hff;
    localparam logic [7:0] PPS0_PPS1    = 8'h10;
    localparam logic [7:0] PPS0_PPS2    = 8'h20;
    localparam logic [2:0] PPS_LAST     = 3'h4;

    typedef enum logic [1:0] {
        C_HOLD = 2'b00,
        C_ATR  = 2'b01,
        C_DATA = 2'b10
    } card_state_t;

    typedef enum logic [2:0] {
        T_IDLE = 3'b000,
        T_TS   = 3'b001,
        T_IF   = 3'b010,
        T_HIST = 3'b011,
        T_TCK  = 3'b100,
        T_DONE = 3'b101,
        T_PPS  = 3'b110
    } term_state_t;
endpackage : atr_pkg

// File: core/atr_link_if.sv
`timescale 1ns/1ps
// Byte-level view of the reset line and the half-duplex I/O line
interface atr_link_if;
    logic       cardRst;
    logic       c2tValid;
    logic [7:0] c2tData;
    logic       c2tReady;
    logic       t2cValid;
    logic [7:0] t2cData;
    logic       t2cReady;

    modport card (input cardRst, output c2tValid, output c2tData, input c2tReady,
                  input t2cValid, input t2cData, output t2cReady);
    modport term (output cardRst, input c2tValid, input c2tData, output c2tReady,
                  output t2cValid, output t2cData, input t2cReady);
endinterface : atr_link_if

// File: core/atr_card_end.sv
// Functional notes
// RQ1 - Card sends ATR first after every reset
// RQ2 - Terminal consumes all interface, historical, check bytes
// RQ3 - ATR always carries T=15 global section
// RQ4 - First historical byte is category 80
// RQ5 - First object is card data service, 31
// RQ6 - Second object is card capabilities, 73
// RQ7 - Both ends support 372/1, 512/8, 512/16
// RQ8 - Other factors need terminal-started selection exchange
// RQ9 - Card advertises F and D in TA1
// RQ10 - DI 0111 means D=64, only FI 1001
// RQ11 - Global bytes follow TDi, i>1, showing T=15
// RQ12 - First TB after T=15 zero if none
// RQ13 - b8 b6 b5 b3 set: low impedance
// RQ14 - Other first-TB values reserved, never sent
// RQ15 - Unusable TA1: try top speed before default
// RQ16 - PPS2 only with first TB, same coding
// RQ17 - Parser walks TDi presence, counts, checks TCK
`timescale 1ns/1ps
module atr_card_end (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    atr_link_if.card         link,
    input  wire logic [7:0]  cfgFiDi,
    input  wire logic [7:0]  cfgClockClass,
    input  wire logic        cfgLowImp,
    input  wire logic [7:0]  cfgService,
    input  wire logic [23:0] cfgCaps,
    input  wire logic        userTxValid,
    input  wire logic [7:0]  userTxData,
    output logic             userTxReady,
    output logic             userRxValid,
    output logic [7:0]       userRxData,
    output logic             atrDone
);
    atr_pkg::card_state_t state;
    logic [3:0] idx;
    logic [7:0] tck;
    logic [7:0] fiDi;
    logic [7:0] clockClass;
    logic [7:0] tb15;
    logic [7:0] service;
    logic [23:0] caps;
    logic [7:0] atrByte;
    logic       sent;

    ////////////////////////////////////////////////////////////////////////////////
    // Factor code check: an unsupported pairing would strand the terminal

    function automatic logic [7:0] safeFiDi(input logic [7:0] f);
        logic ok;
        ok = (f == atr_pkg::FIDI_DEFAULT) || (f == atr_pkg::FIDI_512_8) ||
             (f == atr_pkg::FIDI_512_16) ||
             (f == {atr_pkg::FI_FOR_D64, atr_pkg::DI_D64});            // RQ10
        return ok ? f : atr_pkg::FIDI_512_16;                          // RQ7
    endfunction : safeFiDi

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration is caught while the reset line is held, so one ATR is
    // always self-consistent even if the straps move mid-frame
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            fiDi       <= atr_pkg::FIDI_DEFAULT;
            clockClass <= 8'h00;
            tb15       <= atr_pkg::TB15_NONE;
            service    <= 8'h00;
            caps       <= 24'h000000;
        end else if (state == atr_pkg::C_HOLD) begin
            fiDi       <= safeFiDi(cfgFiDi);                           // RQ9
            clockClass <= cfgClockClass;
            // Only the two legal codings can ever leave the card
            tb15       <= cfgLowImp ? atr_pkg::TB15_LOWIMP
                                    : atr_pkg::TB15_NONE;              // RQ12 RQ13 RQ14
            service    <= cfgService;
            caps       <= cfgCaps;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Byte of the answer selected by index
    always_comb begin
        unique case (idx)
            4'h0:    atrByte = atr_pkg::TS_DIRECT;
            4'h1:    atrByte = atr_pkg::T0_FORMAT;
            4'h2:    atrByte = fiDi;                                   // RQ9
            4'h3:    atrByte = atr_pkg::TD1_BYTE;
            4'h4:    atrByte = atr_pkg::TD2_BYTE;                      // RQ3 RQ11
            4'h5:    atrByte = clockClass;
            4'h6:    atrByte = tb15;                                   // RQ12
            4'h7:    atrByte = atr_pkg::CAT_COMPACT;                   // RQ4
            4'h8:    atrByte = atr_pkg::TAG_SERVICE;                   // RQ5
            4'h9:    atrByte = service;
            4'ha:    atrByte = atr_pkg::TAG_CAPS;                      // RQ6
            4'hb:    atrByte = caps[23:16];
            4'hc:    atrByte = caps[15:8];
            4'hd:    atrByte = caps[7:0];
            default: atrByte = tck;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outgoing line: user bytes are held off until the answer is complete
    assign link.c2tValid = !link.cardRst && ((state == atr_pkg::C_ATR) ||
                           (state == atr_pkg::C_DATA && userTxValid)); // RQ1
    assign link.c2tData  = (state == atr_pkg::C_ATR) ? atrByte : userTxData;
    assign userTxReady   = (state == atr_pkg::C_DATA) && link.c2tReady && !link.cardRst;
    assign sent          = link.c2tValid && link.c2tReady;
    assign atrDone       = (state == atr_pkg::C_DATA);

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer; a reset line pulse restarts the answer from TS
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= atr_pkg::C_HOLD;
            idx   <= 4'h0;
        end else if (link.cardRst) begin
            state <= atr_pkg::C_HOLD;                                  // RQ1
            idx   <= 4'h0;
        end else begin
            unique case (state)
                atr_pkg::C_HOLD: state <= atr_pkg::C_ATR;
                atr_pkg::C_ATR: begin
                    if (sent) begin
                        idx <= idx + 4'h1;
                        if (idx == atr_pkg::ATR_LAST) begin
                            state <= atr_pkg::C_DATA;
                        end
                    end
                end
                default: state <= atr_pkg::C_DATA;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Check byte is the XOR of everything from T0 on
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tck <= 8'h00;
        end else if (state == atr_pkg::C_HOLD) begin
            tck <= 8'h00;
        end else if (state == atr_pkg::C_ATR && sent && idx != 4'h0) begin
            tck <= tck ^ atrByte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Incoming bytes; none are taken before the answer has gone out
    assign link.t2cReady = (state == atr_pkg::C_DATA);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            userRxValid <= 1'b0;
            userRxData  <= 8'h00;
        end else begin
            userRxValid <= link.t2cValid && link.t2cReady;
            if (link.t2cValid && link.t2cReady) begin
                userRxData <= link.t2cData;
            end
        end
    end
endmodule : atr_card_end

// File: core/atr_term_end.sv
`timescale 1ns/1ps
module atr_term_end (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    atr_link_if.term        link,
    input  wire logic       resetReq,
    input  wire logic       hostD64,
    input  wire logic       hostLowImp,
    input  wire logic [7:0] hostMaxFiDi,
    input  wire logic       ppsStart,
    output logic            atrOk,
    output logic            atrError,
    output logic [7:0]      ta1,
    output logic            d64Sel,
    output logic            tb15Present,
    output logic            lowImpAvail,
    output logic            tb15Reserved,
    output logic [15:0]     protoSeen,
    output logic            ppsBusy,
    output logic            userRxValid,
    output logic [7:0]      userRxData
);
    atr_pkg::term_state_t state;
    logic [3:0] need;
    logic [3:0] grp;
    logic [3:0] histLeft;
    logic [7:0] tck;
    logic       tckReq;
    logic       glob;
    logic [7:0] tb15;
    logic [2:0] ppsIdx;
    logic [7:0] ppsByte;
    logic [7:0] pps1;
    logic [7:0] pps2;
    logic [7:0] pck;
    logic [1:0] tries;
    logic       got;
    logic [7:0] b;
    logic [3:0] restNeed;

    assign got           = link.c2tValid && link.c2tReady;
    assign b             = link.c2tData;
    assign link.c2tReady = (state != atr_pkg::T_IDLE) && (state != atr_pkg::T_PPS); // RQ2
    assign link.cardRst  = resetReq || (state == atr_pkg::T_IDLE);
    assign ppsBusy       = (state == atr_pkg::T_PPS);
    // Presence bits left once the lowest pending one is consumed
    assign restNeed      = need & (need - 4'h1);

    ////////////////////////////////////////////////////////////////////////////////
    // Parser walks each group by its presence bits, then history, then TCK
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state    <= atr_pkg::T_IDLE;
            need     <= 4'h0;
            grp      <= 4'h0;
            histLeft <= 4'h0;
            atrOk    <= 1'b0;
            atrError <= 1'b0;
        end else if (resetReq) begin
            state    <= atr_pkg::T_TS;
            atrOk    <= 1'b0;
            atrError <= 1'b0;
        end else begin
            unique case (state)
                atr_pkg::T_IDLE: state <= atr_pkg::T_IDLE;
                atr_pkg::T_TS: if (got) begin
                    need     <= 4'b1000;       // T0 treated as a TD
                    grp      <= 4'h0;
                    atrError <= (b != atr_pkg::TS_DIRECT);
                    state    <= atr_pkg::T_IF;
                end
                atr_pkg::T_IF: if (got) begin
                    if (need[atr_pkg::PRES_TD] && restNeed == 4'h0) begin
                        need <= b[7:4];                                // RQ17
                        grp  <= grp + 4'h1;
                        if (grp == 4'h0) begin
                            histLeft <= b[3:0];
                        end
                        // History always follows; a zero count is skipped below
                        if (b[7:4] == 4'h0) begin
                            state <= atr_pkg::T_HIST;
                        end
                    end else begin
                        need <= restNeed;                              // RQ2
                        if (restNeed == 4'h0) begin
                            state <= atr_pkg::T_HIST;                  // RQ17
                        end
                    end
                end
                atr_pkg::T_HIST: if (got) begin
                    histLeft <= histLeft - 4'h1;
                    if (histLeft == 4'h1) begin
                        state <= atr_pkg::T_TCK;
                    end
                end
                atr_pkg::T_TCK: if (got || !tckReq) begin
                    state    <= atr_pkg::T_DONE;
                    atrOk    <= !atrError && (!tckReq || (tck ^ b) == 8'h00); // RQ17
                    atrError <= atrError || (tckReq && (tck ^ b) != 8'h00);
                end
                atr_pkg::T_DONE: if (ppsStart) begin
                    state <= atr_pkg::T_PPS;
                end
                // A frame without PPS2 ends one byte earlier
                default: if (link.t2cReady && (ppsIdx == atr_pkg::PPS_LAST ||
                                               (ppsIdx == 3'h3 && !tb15Present))) begin
                    state <= atr_pkg::T_DONE;
                end
            endcase
            // History count of zero skips straight to TCK
            if (state == atr_pkg::T_HIST && histLeft == 4'h0) begin
                state <= atr_pkg::T_TCK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Field capture while walking the interface bytes
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ta1       <= atr_pkg::FIDI_DEFAULT;
            tb15      <= atr_pkg::TB15_NONE;
            tb15Present <= 1'b0;
            glob      <= 1'b0;
            tckReq    <= 1'b0;
            protoSeen <= 16'h0000;
            tck       <= 8'h00;
        end else if (state == atr_pkg::T_TS) begin
            ta1       <= atr_pkg::FIDI_DEFAULT;
            tb15Present <= 1'b0;
            glob      <= 1'b0;
            tckReq    <= 1'b0;
            protoSeen <= 16'h0000;
            tck       <= 8'h00;
        end else if (got && state != atr_pkg::T_DONE) begin
            tck <= tck ^ b;
            if (state == atr_pkg::T_IF && need[atr_pkg::PRES_TA] && grp == 4'h1) begin
                ta1 <= b;
            end
            if (state == atr_pkg::T_IF && !need[atr_pkg::PRES_TA] &&
                need[atr_pkg::PRES_TB] && glob && !tb15Present) begin
                tb15        <= b;                                      // RQ11
                tb15Present <= 1'b1;
            end
            if (state == atr_pkg::T_IF && need[atr_pkg::PRES_TD] && restNeed == 4'h0 &&
                grp != 4'h0) begin
                protoSeen[b[3:0]] <= 1'b1;
                tckReq <= tckReq || (b[3:0] != 4'h0);
                // Only TD2 onward may open the global section
                glob   <= (b[3:0] == atr_pkg::PROTO_GLOBAL) && grp >= 4'h2; // RQ11
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded indications
    assign d64Sel       = (ta1 == {atr_pkg::FI_FOR_D64, atr_pkg::DI_D64}); // RQ10
    assign lowImpAvail  = tb15Present &&
                          ((tb15 & atr_pkg::TB15_LOWIMP) == atr_pkg::TB15_LOWIMP); // RQ13
    assign tb15Reserved = tb15Present && !lowImpAvail &&
                          (tb15 != atr_pkg::TB15_NONE);                // RQ14

    ////////////////////////////////////////////////////////////////////////////////
    // Selection request: TA1 if usable, else top speed once, then default
    function automatic logic usable(input logic [7:0] f, input logic d64);
        return (f == atr_pkg::FIDI_DEFAULT) || (f == atr_pkg::FIDI_512_8) ||
               (f == atr_pkg::FIDI_512_16) || (d64 && f == {atr_pkg::FI_FOR_D64,
               atr_pkg::DI_D64});                                      // RQ7 RQ10
    endfunction : usable

    assign pps1 = usable(ta1, hostD64) ? ta1 :
                  (tries == 2'h0) ? hostMaxFiDi : atr_pkg::FIDI_DEFAULT;  // RQ8 RQ15
    assign pps2 = (hostLowImp && lowImpAvail) ? atr_pkg::TB15_LOWIMP
                                              : atr_pkg::TB15_NONE;    // RQ16
    assign pck  = atr_pkg::PPSS_BYTE ^ atr_pkg::PPS0_PPS1 ^
                  (tb15Present ? (atr_pkg::PPS0_PPS2 ^ pps2) : 8'h00) ^ pps1;

    always_comb begin
        unique case (ppsIdx)
            3'h0:    ppsByte = atr_pkg::PPSS_BYTE;
            3'h1:    ppsByte = atr_pkg::PPS0_PPS1 |
                               (tb15Present ? atr_pkg::PPS0_PPS2 : 8'h00); // RQ16
            3'h2:    ppsByte = pps1;
            3'h3:    ppsByte = tb15Present ? pps2 : pck;
            default: ppsByte = pck;
        endcase
    end

    assign link.t2cValid = (state == atr_pkg::T_PPS);
    assign link.t2cData  = ppsByte;

    // PPS2 absent: index 3 carries PCK right after PPS1 and the frame ends there
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ppsIdx <= 3'h0;
            tries  <= 2'h0;
        end else if (state == atr_pkg::T_TS) begin
            ppsIdx <= 3'h0;
            tries  <= 2'h0;
        end else if (state == atr_pkg::T_PPS && link.t2cReady) begin
            if (ppsIdx == atr_pkg::PPS_LAST || (ppsIdx == 3'h3 && !tb15Present)) begin
                ppsIdx <= 3'h0;
                tries  <= (tries == 2'h3) ? tries : tries + 2'h1;
            end else begin
                ppsIdx <= ppsIdx + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // After the answer, card bytes go to the user
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            userRxValid <= 1'b0;
            userRxData  <= 8'h00;
        end else begin
            userRxValid <= got && state == atr_pkg::T_DONE;
            if (got && state == atr_pkg::T_DONE) begin
                userRxData <= b;
            end
        end
    end
endmodule : atr_term_end

// File: tb/atr_link_sva.sv
`timescale 1ns/1ps
module atr_link_sva (
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic       cardRst,
    input wire logic       c2tValid,
    input wire logic [7:0] c2tData,
    input wire logic       c2tReady,
    input wire logic       t2cValid,
    input wire logic [7:0] t2cData,
    input wire logic       t2cReady
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    logic [4:0] idx;
    logic [7:0] acc;

    ////////////////////////////////////////////////////////////////////////////////
    // Index of the byte on offer within the answer, restarted by every card reset
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset || cardRst) begin
            idx <= 5'h00;
        end else if (c2tValid && c2tReady && idx < 5'h0f) begin
            idx <= idx + 5'h01;
        end
    end

    // Running check sum of T0 up to the last capability byte, TS is excluded
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset || cardRst) begin
            acc <= 8'h00;
        end else if (c2tValid && c2tReady && idx != 5'h00 && idx < 5'h0e) begin
            acc <= acc ^ c2tData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    property p_quiet; cardRst |-> !c2tValid; endproperty
    a_quiet: assert property (p_quiet) else $error("byte offered during card reset");
    property p_first; $fell(cardRst) |-> ##[0:2] (c2tValid && c2tData == 8'h3b); endproperty
    a_first: assert property (p_first) else $error("answer does not open with TS");
    property p_burst; c2tValid && c2tReady && idx < 5'h0e |=> c2tValid; endproperty
    a_burst: assert property (p_burst) else $error("gap inside the answer");
    property p_hold; c2tValid && !c2tReady && !cardRst |=> c2tValid && $stable(c2tData);
    endproperty
    a_hold: assert property (p_hold) else $error("card byte changed before taken");
    property p_format; c2tValid && idx == 5'h01 |-> c2tData == 8'h97; endproperty
    a_format: assert property (p_format) else $error("format byte wrong");
    property p_ta1; c2tValid && idx == 5'h02 |-> c2tData inside {8'h11, 8'h94, 8'h95, 8'h97};
    endproperty
    a_ta1: assert property (p_ta1) else $error("factor byte not a supported pair");
    property p_global; c2tValid && idx == 5'h04 |-> c2tData[3:0] == 4'hf; endproperty
    a_global: assert property (p_global) else $error("global section not flagged");
    property p_tb15; c2tValid && idx == 5'h06 |-> c2tData inside {8'h00, 8'hb4}; endproperty
    a_tb15: assert property (p_tb15) else $error("reserved first TB value sent");
    property p_cat; c2tValid && idx == 5'h07 |-> c2tData == 8'h80; endproperty
    a_cat: assert property (p_cat) else $error("category byte wrong");
    property p_svc; c2tValid && idx == 5'h08 |-> c2tData == 8'h31; endproperty
    a_svc: assert property (p_svc) else $error("service tag wrong");
    property p_caps; c2tValid && idx == 5'h0a |-> c2tData == 8'h73; endproperty
    a_caps: assert property (p_caps) else $error("capability tag wrong");
    property p_tck; c2tValid && idx == 5'h0e |-> c2tData == acc; endproperty
    a_tck: assert property (p_tck) else $error("check byte wrong");
    property p_pps; $rose(t2cValid) |-> t2cData == 8'hff; endproperty
    a_pps: assert property (p_pps) else $error("selection frame lacks its start byte");
    property p_t2cHold; t2cValid && !t2cReady |=> t2cValid && $stable(t2cData); endproperty
    a_t2cHold: assert property (p_t2cHold) else $error("terminal byte changed early");
endmodule : atr_link_sva

// File: tb/atr_content_builder_parser_tb.sv
`timescale 1ns/1ps
module atr_content_builder_parser_tb;
    logic       clk_sys = 1'b0;
    logic       reset   = 1'b1;
    logic [7:0] cfgFiDi = 8'h95;
    logic       cfgLowImp = 1'b0;
    logic       userTxValid = 1'b0;
    logic [7:0] userTxData = 8'h00;
    logic       resetReq = 1'b0;
    logic       hostLowImp = 1'b0;
    logic       ppsStart = 1'b0;
    logic       txReady, cRxValid, atrDone, atrOk, atrError, d64Sel, tb15Present;
    logic       lowImpAvail, tb15Reserved, ppsBusy, tRxValid;
    logic [7:0] cRxData, ta1, tRxData;
    logic [15:0] protoSeen;
    logic [7:0] atrQ[$];
    logic [7:0] ppsQ[$];
    int         errorCnt = 0;
    int         cmpCount = 0;

    atr_link_if link ();

    // Clock of 100 MHz
    always #5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    atr_card_end atr_card_end_inst (.clk_sys(clk_sys), .reset(reset), .link(link),
        .cfgFiDi(cfgFiDi), .cfgClockClass(8'h07), .cfgLowImp(cfgLowImp), .cfgService(8'hc1),
        .cfgCaps(24'h0a1b2c), .userTxValid(userTxValid), .userTxData(userTxData),
        .userTxReady(txReady), .userRxValid(cRxValid), .userRxData(cRxData), .atrDone(atrDone));
    atr_term_end atr_term_end_inst (.clk_sys(clk_sys), .reset(reset), .link(link),
        .resetReq(resetReq), .hostD64(1'b0), .hostLowImp(hostLowImp), .hostMaxFiDi(8'h95),
        .ppsStart(ppsStart), .atrOk(atrOk), .atrError(atrError), .ta1(ta1), .d64Sel(d64Sel),
        .tb15Present(tb15Present), .lowImpAvail(lowImpAvail), .tb15Reserved(tb15Reserved),
        .protoSeen(protoSeen), .ppsBusy(ppsBusy), .userRxValid(tRxValid), .userRxData(tRxData));
    atr_link_sva atr_link_sva_inst (.clk_sys(clk_sys), .reset(reset), .cardRst(link.cardRst),
        .c2tValid(link.c2tValid), .c2tData(link.c2tData), .c2tReady(link.c2tReady),
        .t2cValid(link.t2cValid), .t2cData(link.t2cData), .t2cReady(link.t2cReady));

    // Bytes taken on either direction of the line
    always @(posedge clk_sys) begin
        if (link.c2tValid && link.c2tReady) atrQ.push_back(link.c2tData);
        if (link.t2cValid && link.t2cReady) ppsQ.push_back(link.t2cData);
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        cmpCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check8

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude

    // A bound that runs out ends the run, since later steps would only cascade
    task automatic timeout_hit();
        errorCnt++;
        $display("wrong value at %0t ns: got %h expected %h", $time, 8'h00, 8'h01);
        conclude();
    endtask : timeout_hit

    // Restart the card and compare the whole answer byte by byte
    task automatic atr_case(input logic [7:0] fidi, input logic lowImp, input logic [7:0] expTa1);
        logic [7:0] exp[15];
        int n;
        exp = '{8'h3b, 8'h97, expTa1, 8'h80, 8'h3f, 8'h07, lowImp ? 8'hb4 : 8'h00, 8'h80,
                8'h31, 8'hc1, 8'h73, 8'h0a, 8'h1b, 8'h2c, 8'h00};
        for (n = 1; n < 14; n++) exp[14] = exp[14] ^ exp[n];
        @(posedge clk_sys);
        atrQ = {};
        cfgFiDi <= fidi;
        cfgLowImp <= lowImp;
        resetReq <= 1'b1;
        @(posedge clk_sys);
        resetReq <= 1'b0;
        for (n = 0; n < 200 && atrQ.size() < 15; n++) @(posedge clk_sys);
        if (n == 200) timeout_hit();
        repeat (3) @(posedge clk_sys);
        check8(8'(atrQ.size()), 8'h0f);
        for (n = 0; n < 15; n++) check8(atrQ[n], exp[n]);
        check8(ta1, expTa1);
        check8({atrOk, atrError, tb15Present, lowImpAvail, tb15Reserved, d64Sel, atrDone, 1'b0},
               {4'b1010, 4'h2} | {3'b000, lowImp, 1'b0, expTa1 == 8'h97, 2'b00});
        check8(protoSeen[15:8], 8'h80);
        $display("test atr fidi %h lowimp %0d done", fidi, lowImp);
    endtask : atr_case

    // Each mandatory pair is sent as asked, an unsupported one falls back
    task automatic factor_table();
        atr_case(8'h11, 1'b0, 8'h11);
        atr_case(8'h94, 1'b0, 8'h94);
        atr_case(8'h95, 1'b0, 8'h95);
        atr_case(8'h13, 1'b0, 8'h95);
    endtask : factor_table

    // User byte sent after the answer is complete reaches the terminal
    task automatic user_pass();
        int n;
        userTxValid <= 1'b1;
        userTxData <= 8'h5a;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (txReady) break;
        end
        userTxValid <= 1'b0;
        if (n == 50) timeout_hit();
        for (n = 0; n < 50 && !tRxValid; n++) @(posedge clk_sys);
        if (n == 50) timeout_hit();
        check8(tRxData, 8'h5a);
        $display("test user byte done");
    endtask : user_pass

    // Selection frame: TA1 taken if usable, else the host's top speed first
    task automatic pps_case(input logic [7:0] fidi, input logic lowImp, input logic [7:0] p1,
                            input logic [7:0] p2);
        logic [7:0] exp[5];
        int n;
        exp = '{8'hff, 8'h30, p1, p2, 8'hff ^ 8'h30 ^ p1 ^ p2};
        atr_case(fidi, lowImp, fidi);
        ppsQ = {};
        hostLowImp <= lowImp;
        ppsStart <= 1'b1;
        @(posedge clk_sys);
        ppsStart <= 1'b0;
        repeat (2) @(posedge clk_sys);
        for (n = 0; n < 100 && ppsBusy; n++) @(posedge clk_sys);
        if (n == 100) timeout_hit();
        check8(8'(ppsQ.size()), 8'h05);
        for (n = 0; n < 5 && n < ppsQ.size(); n++) check8(ppsQ[n], exp[n]);
        check8(cRxData, exp[4]);
        $display("test selection frame done");
    endtask : pps_case

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        factor_table();
        user_pass();
        pps_case(8'h94, 1'b1, 8'h94, 8'hb4);
        pps_case(8'h97, 1'b0, 8'h95, 8'h00);
        conclude();
    end
endmodule : atr_content_builder_parser_tb
